// ===== src/fault_detect_defs.svh
`ifndef FAULT_DETECT_DEFS_SVH
`define FAULT_DETECT_DEFS_SVH

`define ADDR_STATUS        4'h0
`define ADDR_MASK          4'h1
`define ADDR_CONFIG        4'h2
`define ADDR_RUN_THRESH    4'h3
`define ADDR_HOST_LIMIT    4'h4
`define ADDR_COMMAND       4'h5
`define ADDR_RUN_TOTAL     4'h6
`define ADDR_CODE          4'h7

`define CFG_SENSOR_EN_BIT  0
`define CFG_OPEN_ALARM_BIT 1
`define CFG_CONST_CUR_BIT  2
`define CFG_RESET          8'h03

`define CMD_RESET_BIT      0
`define CMD_RUN_CLEAR_BIT  1
`define CMD_MAIN_WRITE_BIT 2

`define MASK_RESET         8'hff
`define RUN_THRESH_RESET   32'hffffffff
`define HOST_LIMIT_RESET   16'h0000

`define OVER_PCT           10'd120
`define OVER_CYCLES        9'd250
`define FREQ_MIN_HZ        8'd47
`define FREQ_MAX_HZ        8'd63
`define FREQ_RATE_HZ_S     8'd3

`define CLK_HZ             100000000
`define TICK_MS            1
`define TICK_CYCLES        ((`CLK_HZ / 1000) * `TICK_MS)
`define HOUR_TICKS         3600000

`define SENSOR_FAULT_CODE       8'h12
`define OVERCURRENT_CODE        8'h20
`define ZERO_CROSS_FAULT_CODE   8'h30
`define LINE_FREQ_FAULT_CODE    8'h31
`define INPUT_RANGE_ALARM_CODE  8'h50
`define DUTY_INPUT_ALARM_CODE   8'h51
`define RUN_TIME_ALARM_CODE     8'h60
`define HOST_TIMEOUT_ALARM_CODE 8'h70

`endif

// ===== src/fault_detect_pkg.sv
package fault_detect_pkg;
  typedef enum logic [2:0]
  {
    F_SENSOR = 3'd0,
    F_OVER   = 3'd1,
    F_ZERO   = 3'd2,
    F_FREQ   = 3'd3,
    F_RANGE  = 3'd4,
    F_DUTY   = 3'd5,
    F_RUN    = 3'd6,
    F_HOST   = 3'd7
  } fault_idx_e;

  typedef logic [7:0] fault_vec_t;
endpackage

// ===== src/fault_flags_if.sv
`timescale 1ns/10ps
interface fault_flags_if;
  logic [7:0] event_set;
  logic [7:0] reset_clear;
  logic [7:0] w1c_clear;
  logic [7:0] status;

  modport owner
  (
    input  event_set,
    input  reset_clear,
    input  w1c_clear,
    output status
  );
  modport user
  (
    output event_set,
    output reset_clear,
    output w1c_clear,
    input  status
  );
endinterface

// ===== src/fault_flags.sv
`timescale 1ns/10ps
module fault_flags
(
  // Clock and reset
  input  wire logic    clock_in,
  input  wire logic    rst_n_in,
  // Flag traffic
  fault_flags_if.owner flags
);
  logic [7:0] status_r;

  assign flags.status = status_r;

  // Set beats clear, so an event in the clearing cycle survives
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      status_r <= 8'h00;
    else
      status_r <= flags.event_set |
                  (status_r & ~(flags.reset_clear | flags.w1c_clear));
  end
endmodule

// ===== src/fault_detect_monitor.sv
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`include "fault_detect_defs.svh"
module fault_detect_monitor
  import fault_detect_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  // Register port
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [31:0] reg_wdata_in,
  input  wire logic        reg_write_in,
  input  wire logic        reg_read_in,
  output logic      [31:0] reg_rdata_out,
  // Reset sources from outside
  input  wire logic        panel_reset_key_in,
  input  wire logic        reset_pin_in,
  // Sensing, from the analog front end
  input  wire logic        sensor_fail_in,
  input  wire logic        all_heaters_open_in,
  input  wire logic [9:0]  load_pct_in,
  input  wire logic        zero_cross_in,
  input  wire logic        zero_cross_missing_in,
  input  wire logic [7:0]  line_freq_hz_in,
  input  wire logic [7:0]  freq_rate_hz_s_in,
  input  wire logic        loop_out_of_range_in,
  input  wire logic        volt_out_of_range_in,
  input  wire logic        pot_main_out_of_range_in,
  input  wire logic        pot_duty_out_of_range_in,
  input  wire logic        running_in,
  // Alarm outputs
  output logic             alarm_contact_out,
  output logic             irq_out,
  output logic      [7:0]  fault_code_out
);
  // Pin synchronisers, first stage read only by second
  logic [12:0] pin_meta_r;
  logic [12:0] pin_sync_r;
  logic [9:0]  load_meta_r;
  logic [9:0]  load_sync_r;
  logic [7:0]  freq_meta_r;
  logic [7:0]  freq_sync_r;
  logic [7:0]  rate_meta_r;
  logic [7:0]  rate_sync_r;

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pin_meta_r  <= 13'h0000;
      pin_sync_r  <= 13'h0000;
      load_meta_r <= 10'h000;
      load_sync_r <= 10'h000;
      freq_meta_r <= 8'h32;
      freq_sync_r <= 8'h32;
      rate_meta_r <= 8'h00;
      rate_sync_r <= 8'h00;
    end
    else
    begin
      pin_meta_r  <= {panel_reset_key_in, reset_pin_in, sensor_fail_in,
                      all_heaters_open_in, zero_cross_in,
                      zero_cross_missing_in, loop_out_of_range_in,
                      volt_out_of_range_in, pot_main_out_of_range_in,
                      pot_duty_out_of_range_in, running_in, 2'b00};
      pin_sync_r  <= pin_meta_r;
      load_meta_r <= load_pct_in;
      load_sync_r <= load_meta_r;
      freq_meta_r <= line_freq_hz_in;
      freq_sync_r <= freq_meta_r;
      rate_meta_r <= freq_rate_hz_s_in;
      rate_sync_r <= rate_meta_r;
    end
  end

  logic key_s, rpin_s, sfail_s, hopen_s, zc_s, zmiss_s;
  logic loop_s, volt_s, pmain_s, pduty_s, run_s;
  assign key_s   = pin_sync_r[12];
  assign rpin_s  = pin_sync_r[11];
  assign sfail_s = pin_sync_r[10];
  assign hopen_s = pin_sync_r[9];
  assign zc_s    = pin_sync_r[8];
  assign zmiss_s = pin_sync_r[7];
  assign loop_s  = pin_sync_r[6];
  assign volt_s  = pin_sync_r[5];
  assign pmain_s = pin_sync_r[4];
  assign pduty_s = pin_sync_r[3];
  assign run_s   = pin_sync_r[2];

  // Software registers
  logic [7:0]  mask_r;
  logic [7:0]  config_r;
  logic [31:0] run_thresh_r;
  logic [15:0] host_limit_r;
  logic        sw_reset_r;
  logic        run_clear_r;
  logic        main_write_r;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    hit = (a == off);
  endfunction

  logic [7:0] status;
  logic [7:0] w1c;

  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      mask_r       <= `MASK_RESET;
      config_r     <= `CFG_RESET;
      run_thresh_r <= `RUN_THRESH_RESET;
      host_limit_r <= `HOST_LIMIT_RESET;
    end
    else if (reg_write_in)
    begin
      if (hit(reg_addr_in, `ADDR_MASK))
        mask_r <= reg_wdata_in[7:0];
      else if (hit(reg_addr_in, `ADDR_CONFIG))
        config_r <= {5'h00, reg_wdata_in[2:0]};
      else if (hit(reg_addr_in, `ADDR_RUN_THRESH))
        run_thresh_r <= reg_wdata_in;
      else if (hit(reg_addr_in, `ADDR_HOST_LIMIT))
        host_limit_r <= reg_wdata_in[15:0];
    end
  end

  // Command strobes, one cycle each
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sw_reset_r   <= 1'b0;
      run_clear_r  <= 1'b0;
      main_write_r <= 1'b0;
    end
    else
    begin
      sw_reset_r   <= reg_write_in & hit(reg_addr_in, `ADDR_COMMAND) &
                      reg_wdata_in[`CMD_RESET_BIT];
      run_clear_r  <= reg_write_in & hit(reg_addr_in, `ADDR_COMMAND) &
                      reg_wdata_in[`CMD_RUN_CLEAR_BIT];
      main_write_r <= reg_write_in & hit(reg_addr_in, `ADDR_COMMAND) &
                      reg_wdata_in[`CMD_MAIN_WRITE_BIT];
    end
  end

  assign w1c = (reg_write_in && hit(reg_addr_in, `ADDR_STATUS)) ?
               reg_wdata_in[7:0] : 8'h00;

  // Reset request from key, pin or host
  logic key_d_r, rpin_d_r;
  logic reset_req;
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      key_d_r  <= 1'b0;
      rpin_d_r <= 1'b0;
    end
    else
    begin
      key_d_r  <= key_s;
      rpin_d_r <= rpin_s;
    end
  end
  assign reset_req = (key_s & ~key_d_r) | (rpin_s & ~rpin_d_r) |
                     sw_reset_r;

  // Mains cycle edge
  logic zc_d_r, zc_edge;
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      zc_d_r <= 1'b0;
    else
      zc_d_r <= zc_s;
  end
  assign zc_edge = zc_s & ~zc_d_r;

  // Overcurrent cycle counter
  logic [8:0] over_cnt_r;
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      over_cnt_r <= 9'h000;
    else if (load_sync_r <= `OVER_PCT)
      over_cnt_r <= 9'h000;
    else if (zc_edge && over_cnt_r != `OVER_CYCLES)
      over_cnt_r <= over_cnt_r + 9'h001;
  end

  // Millisecond tick, then hours of run time
  logic [16:0] tick_cnt_r;
  logic        tick;
  assign tick = (tick_cnt_r == 17'(`TICK_CYCLES - 1));
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      tick_cnt_r <= 17'h00000;
    else if (tick)
      tick_cnt_r <= 17'h00000;
    else
      tick_cnt_r <= tick_cnt_r + 17'h00001;
  end

  logic [21:0] hour_cnt_r;
  logic [31:0] run_total_r;
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      hour_cnt_r  <= 22'h000000;
      run_total_r <= 32'h00000000;
    end
    else if (run_clear_r)
    begin
      hour_cnt_r  <= 22'h000000;
      run_total_r <= 32'h00000000;
    end
    else if (tick && run_s)
    begin
      if (hour_cnt_r == 22'(`HOUR_TICKS - 1))
      begin
        hour_cnt_r <= 22'h000000;
        if (run_total_r != 32'hffffffff)
          run_total_r <= run_total_r + 32'h00000001;
      end
      else
        hour_cnt_r <= hour_cnt_r + 22'h000001;
    end
  end

  // Host silence timer in milliseconds
  logic [15:0] host_cnt_r;
  logic        host_access;
  assign host_access = reg_write_in | reg_read_in;
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      host_cnt_r <= 16'h0000;
    else if (host_access || host_limit_r == 16'h0000)
      host_cnt_r <= 16'h0000;
    else if (tick && host_cnt_r != host_limit_r)
      host_cnt_r <= host_cnt_r + 16'h0001;
  end

  // Fault detection
  logic [7:0] det;
  logic       freq_bad;
  assign freq_bad = (freq_sync_r < `FREQ_MIN_HZ ||
                     freq_sync_r > `FREQ_MAX_HZ) &&
                    rate_sync_r >= `FREQ_RATE_HZ_S;
  always_comb
  begin
    det         = 8'h00;
    det[F_SENSOR] = config_r[`CFG_SENSOR_EN_BIT] &
                    (sfail_s | (config_r[`CFG_CONST_CUR_BIT] & hopen_s));
    det[F_OVER]   = (over_cnt_r == `OVER_CYCLES);
    det[F_ZERO]   = zmiss_s;
    det[F_FREQ]   = freq_bad;
    det[F_RANGE]  = loop_s | volt_s | pmain_s;
    det[F_DUTY]   = pduty_s;
    det[F_RUN]    = (run_total_r > run_thresh_r);
    det[F_HOST]   = (host_limit_r != 16'h0000) &&
                    (host_cnt_r == host_limit_r);
  end

  // Latched faults; host timeout clears on main setting write only
  logic [7:0] latched_r;
  logic [7:0] clr;
  always_comb
  begin
    clr         = reset_req ? 8'hff : 8'h00;
    clr[F_HOST] = main_write_r;
  end
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      latched_r <= 8'h00;
    else
      latched_r <= det | (latched_r & ~clr);
  end

  fault_flags_if flags_if ();
  assign flags_if.event_set   = det;
  assign flags_if.reset_clear = clr;
  assign flags_if.w1c_clear   = w1c;
  assign status               = flags_if.status;

  fault_flags u_flags
  (
    .clock_in (clock_in),
    .rst_n_in (rst_n_in),
    .flags    (flags_if)
  );

  function automatic logic [7:0] code_of(input logic [7:0] v);
    code_of = 8'h00;
    if (v[F_SENSOR])      code_of = `SENSOR_FAULT_CODE;
    else if (v[F_OVER])   code_of = `OVERCURRENT_CODE;
    else if (v[F_ZERO])   code_of = `ZERO_CROSS_FAULT_CODE;
    else if (v[F_FREQ])   code_of = `LINE_FREQ_FAULT_CODE;
    else if (v[F_RANGE])  code_of = `INPUT_RANGE_ALARM_CODE;
    else if (v[F_DUTY])   code_of = `DUTY_INPUT_ALARM_CODE;
    else if (v[F_RUN])    code_of = `RUN_TIME_ALARM_CODE;
    else if (v[F_HOST])   code_of = `HOST_TIMEOUT_ALARM_CODE;
  endfunction

  // Outputs, all registered
  logic in_alarm;
  assign in_alarm = |latched_r;
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      alarm_contact_out <= 1'b1;
      irq_out           <= 1'b0;
      fault_code_out    <= 8'h00;
    end
    else
    begin
      // Open in alarm means contact low while faulted
      alarm_contact_out <= config_r[`CFG_OPEN_ALARM_BIT] ?
                           ~in_alarm : in_alarm;
      irq_out           <= |(status & mask_r);
      fault_code_out    <= code_of(latched_r);
    end
  end

  // Read data, stands only in the cycle after the strobe
  always_ff @(posedge clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      reg_rdata_out <= 32'h00000000;
    else if (!reg_read_in)
      reg_rdata_out <= 32'h00000000;
    else if (hit(reg_addr_in, `ADDR_STATUS))
      reg_rdata_out <= {24'h000000, status};
    else if (hit(reg_addr_in, `ADDR_MASK))
      reg_rdata_out <= {24'h000000, mask_r};
    else if (hit(reg_addr_in, `ADDR_CONFIG))
      reg_rdata_out <= {24'h000000, config_r};
    else if (hit(reg_addr_in, `ADDR_RUN_THRESH))
      reg_rdata_out <= run_thresh_r;
    else if (hit(reg_addr_in, `ADDR_HOST_LIMIT))
      reg_rdata_out <= {16'h0000, host_limit_r};
    else if (hit(reg_addr_in, `ADDR_RUN_TOTAL))
      reg_rdata_out <= run_total_r;
    else if (hit(reg_addr_in, `ADDR_CODE))
      reg_rdata_out <= {16'h0000, latched_r, code_of(latched_r)};
    else
      reg_rdata_out <= 32'h00000000;
  end
endmodule

// ===== tb/fault_detect_chk.sv
`timescale 1ns/10ps
`include "fault_detect_defs.svh"
module fault_detect_chk
(
  // Clock and reset
  input wire logic        clock_in,
  input wire logic        rst_n_in,
  // Register port
  input wire logic [3:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_write_in,
  input wire logic        reg_read_in,
  input wire logic [31:0] reg_rdata_out,
  // Reset sources and sensing
  input wire logic        panel_reset_key_in,
  input wire logic        reset_pin_in,
  input wire logic        sensor_fail_in,
  input wire logic [9:0]  load_pct_in,
  input wire logic        zero_cross_in,
  input wire logic        zero_cross_missing_in,
  input wire logic [7:0]  line_freq_hz_in,
  input wire logic [7:0]  freq_rate_hz_s_in,
  input wire logic        loop_out_of_range_in,
  input wire logic        volt_out_of_range_in,
  input wire logic        pot_main_out_of_range_in,
  input wire logic        pot_duty_out_of_range_in,
  // Alarm outputs
  input wire logic        alarm_contact_out,
  input wire logic [7:0]  fault_code_out
);
  logic [7:0] cfg_r;
  logic       lim_zero_r;
  logic [2:0] quiet_r;
  logic [8:0] edges_r;
  logic       zc_r;
  wire        zc_rise = zero_cross_in && !zc_r;
  wire        any_bad = (line_freq_hz_in < 8'd47 || line_freq_hz_in > 8'd63)
                        && freq_rate_hz_s_in >= 8'd3;

  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  // Mirror of config and limit so polarity and disable can be judged
  always_ff @(posedge clock_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      cfg_r      <= `CFG_RESET;
      lim_zero_r <= 1'b1;
    end
    else if (reg_write_in)
    begin
      if (reg_addr_in == `ADDR_CONFIG)
        cfg_r <= reg_wdata_in[7:0];
      if (reg_addr_in == `ADDR_HOST_LIMIT)
        lim_zero_r <= (reg_wdata_in[15:0] == 16'h0000);
    end

  // Cycles since any possible clearing source, saturating
  always_ff @(posedge clock_in or negedge rst_n_in)
    if (!rst_n_in)
      quiet_r <= 3'd0;
    else if (panel_reset_key_in || reset_pin_in || reg_write_in)
      quiet_r <= 3'd0;
    else if (quiet_r != 3'd7)
      quiet_r <= quiet_r + 3'd1;

  // Mains cycles seen with load above the overcurrent level
  always_ff @(posedge clock_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      zc_r    <= 1'b0;
      edges_r <= 9'd0;
    end
    else
    begin
      zc_r    <= zero_cross_in;
      if (load_pct_in <= `OVER_PCT)
        edges_r <= 9'd0;
      else if (zc_rise)
        edges_r <= edges_r + 9'd1;
    end

  property p_sensor;
    (sensor_fail_in && cfg_r[0])[*4] |-> ##[0:2]
      fault_code_out == `SENSOR_FAULT_CODE;
  endproperty
  a_sensor: assert property (p_sensor)
    else $error("sensor fault not reported");
  property p_over;
    edges_r == 9'd249 && zc_rise && load_pct_in > `OVER_PCT |->
      ##[1:6] fault_code_out != 8'h00;
  endproperty
  a_over: assert property (p_over)
    else $error("overcurrent not reported");
  property p_latch;
    quiet_r == 3'd7 && fault_code_out != 8'h00 |=> fault_code_out != 8'h00;
  endproperty
  a_latch: assert property (p_latch)
    else $error("latched fault dropped without reset request");
  property p_zero;
    zero_cross_missing_in[*4] |-> ##[0:2] fault_code_out != 8'h00;
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero cross fault not reported");
  property p_freq;
    any_bad[*4] |-> ##[0:2] fault_code_out != 8'h00;
  endproperty
  a_freq: assert property (p_freq)
    else $error("frequency fault not reported");
  property p_range;
    (loop_out_of_range_in || volt_out_of_range_in ||
     pot_main_out_of_range_in)[*4] |-> ##[0:2] fault_code_out != 8'h00;
  endproperty
  a_range: assert property (p_range)
    else $error("input range alarm not reported");
  property p_duty;
    pot_duty_out_of_range_in[*4] |-> ##[0:2] fault_code_out != 8'h00;
  endproperty
  a_duty: assert property (p_duty)
    else $error("duty input alarm not reported");
  property p_host_off;
    lim_zero_r && fault_code_out != `HOST_TIMEOUT_ALARM_CODE |=>
      fault_code_out != `HOST_TIMEOUT_ALARM_CODE;
  endproperty
  a_host_off: assert property (p_host_off)
    else $error("host timeout raised while disabled");
  property p_polarity;
    $stable(cfg_r) && $stable(fault_code_out) |->
      alarm_contact_out == ((fault_code_out != 8'h00) ^ cfg_r[1]);
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("alarm contact level wrong");
  property p_rdata_idle;
    !$past(reg_read_in) |-> reg_rdata_out == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside read slot");

  c_sensor: cover property (fault_code_out == `SENSOR_FAULT_CODE);
  c_over:   cover property (fault_code_out == `OVERCURRENT_CODE);
  c_closed: cover property (!cfg_r[1] && alarm_contact_out);
endmodule

bind fault_detect_monitor fault_detect_chk chk
(
  .clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
  .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
  .panel_reset_key_in(panel_reset_key_in), .reset_pin_in(reset_pin_in),
  .sensor_fail_in(sensor_fail_in), .load_pct_in(load_pct_in),
  .zero_cross_in(zero_cross_in), .zero_cross_missing_in(zero_cross_missing_in),
  .line_freq_hz_in(line_freq_hz_in), .freq_rate_hz_s_in(freq_rate_hz_s_in),
  .loop_out_of_range_in(loop_out_of_range_in),
  .volt_out_of_range_in(volt_out_of_range_in),
  .pot_main_out_of_range_in(pot_main_out_of_range_in),
  .pot_duty_out_of_range_in(pot_duty_out_of_range_in),
  .alarm_contact_out(alarm_contact_out), .fault_code_out(fault_code_out)
);

// ===== tb/host_link_model.sv
`timescale 1ns/10ps
`include "fault_detect_defs.svh"
module host_link_model
(
  // Clock
  input  wire logic        clock_in,
  // Register port toward the monitor
  output logic      [3:0]  addr_out,
  output logic      [31:0] wdata_out,
  output logic             write_out,
  output logic             read_out,
  input  wire logic [31:0] rdata_in
);
  initial
  begin
    addr_out = 4'h0;
    wdata_out = 32'h0;
    write_out = 1'b0;
    read_out = 1'b0;
  end

  // Released lines show the inverse so stale values cannot pass
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock_in);
    addr_out <= a;
    wdata_out <= d;
    write_out <= 1'b1;
    @(posedge clock_in);
    write_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock_in);
    addr_out <= a;
    read_out <= 1'b1;
    @(posedge clock_in);
    read_out <= 1'b0;
    addr_out <= ~a;
    // Data stands only in this cycle; take it at its closing edge
    @(posedge clock_in);
    d = rdata_in;
  endtask

  task automatic host_reset();
    wr(`ADDR_COMMAND, 32'h1);
  endtask
  task automatic run_clear();
    wr(`ADDR_COMMAND, 32'h2);
  endtask
  task automatic main_write();
    wr(`ADDR_COMMAND, 32'h4);
  endtask
endmodule

// ===== tb/fault_detect_monitor_bench.sv
`timescale 1ns/10ps
`include "fault_detect_defs.svh"
module fault_detect_monitor_bench;
  import fault_detect_pkg::*;
  logic        clock_in, rst_n_in, reg_write_in, reg_read_in;
  logic [3:0]  reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, d;
  logic        key, pin, sfail, hopen, zc, zmiss, loop_bad, volt_bad;
  logic        pmain_bad, pduty_bad, running, alarm_contact_out, irq_out;
  logic [9:0]  load;
  logic [7:0]  freq, rate, fault_code_out;
  int          n_errors, n_compared, cyc, idx, sub;
  int          seed = 32'hb236;

  fault_detect_monitor uut
  (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_write_in(reg_write_in),
    .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
    .panel_reset_key_in(key), .reset_pin_in(pin), .sensor_fail_in(sfail),
    .all_heaters_open_in(hopen), .load_pct_in(load), .zero_cross_in(zc),
    .zero_cross_missing_in(zmiss), .line_freq_hz_in(freq),
    .freq_rate_hz_s_in(rate), .loop_out_of_range_in(loop_bad),
    .volt_out_of_range_in(volt_bad), .pot_main_out_of_range_in(pmain_bad),
    .pot_duty_out_of_range_in(pduty_bad), .running_in(running),
    .alarm_contact_out(alarm_contact_out), .irq_out(irq_out),
    .fault_code_out(fault_code_out)
  );
  host_link_model host
  (
    .clock_in(clock_in), .addr_out(reg_addr_in), .wdata_out(reg_wdata_in),
    .write_out(reg_write_in), .read_out(reg_read_in), .rdata_in(reg_rdata_out)
  );

  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  function automatic logic [7:0] exp_code(input int i);
    case (i)
      0: return `SENSOR_FAULT_CODE;
      2: return `ZERO_CROSS_FAULT_CODE;
      3: return `LINE_FREQ_FAULT_CODE;
      4: return `INPUT_RANGE_ALARM_CODE;
      default: return `DUTY_INPUT_ALARM_CODE;
    endcase
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clock_in);
  endtask

  // Off state keeps the mains inside its band with random drift
  task automatic drive(input int i, input int s, input logic on);
    @(posedge clock_in);
    case (i)
      0: sfail <= on;
      2: zmiss <= on;
      3:
      begin
        freq <= on ? (s == 0 ? 8'd46 : 8'd64)
                   : 8'd47 + 8'($unsigned($random(seed)) % 17);
        rate <= on ? 8'd3 : 8'($random(seed));
      end
      4:
      begin
        loop_bad <= on && s == 0;
        volt_bad <= on && s == 1;
        pmain_bad <= on && s == 2;
      end
      default: pduty_bad <= on;
    endcase
  endtask

  task automatic clear(input int s);
    if (s == 2)
      host.host_reset();
    else
    begin
      @(posedge clock_in);
      key <= (s == 0);
      pin <= (s == 1);
      cyc_wait(2);
      key <= 1'b0;
      pin <= 1'b0;
    end
    cyc_wait(8);
  endtask

  task automatic mains(input int n);
    repeat (n)
    begin
      @(posedge clock_in) zc <= 1'b1;
      @(posedge clock_in) zc <= 1'b0;
      cyc_wait(2);
    end
    cyc_wait(8);
  endtask

  task automatic results();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Whole run needs about 2800 cycles
  always @(posedge clock_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      results();
    end
  end

  initial
  begin
    {key, pin, sfail, hopen, zc, zmiss, loop_bad, volt_bad} = 8'h00;
    {pmain_bad, pduty_bad, running} = 3'b000;
    load = 10'd50;
    freq = 8'd50;
    rate = 8'd0;
    rst_n_in = 1'b0;
    cyc_wait(2);
    rst_n_in <= 1'b1;
    host.rd(`ADDR_MASK, d);
    check(d, 32'hff);
    host.rd(4'h8, d);
    check(d, 32'h0);
    host.rd(`ADDR_HOST_LIMIT, d);
    check(d, 32'h0);
    host.main_write();
    cyc_wait(8);
    check(fault_code_out, 8'h00);
    $display("test registers done");
    repeat (20)
    begin
      idx = $unsigned($random(seed)) % 5;
      idx = (idx == 1) ? 5 : idx;
      sub = $unsigned($random(seed)) % 3;
      drive(idx, sub, 1'b1);
      cyc_wait(8);
      check(fault_code_out, exp_code(idx));
      check(alarm_contact_out, 1'b0);
      check(irq_out, 1'b1);
      drive(idx, sub, 1'b0);
      cyc_wait(8);
      check(fault_code_out, exp_code(idx));
      clear(sub);
      check(fault_code_out, 8'h00);
    end
    $display("test random faults done");
    host.wr(`ADDR_CONFIG, 32'h2);
    drive(0, 0, 1'b1);
    cyc_wait(8);
    check(fault_code_out, 8'h00);
    drive(0, 0, 1'b0);
    hopen <= 1'b1;
    host.wr(`ADDR_CONFIG, 32'h3);
    cyc_wait(8);
    check(fault_code_out, 8'h00);
    host.wr(`ADDR_CONFIG, 32'h7);
    cyc_wait(8);
    check(fault_code_out, `SENSOR_FAULT_CODE);
    hopen <= 1'b0;
    host.wr(`ADDR_CONFIG, 32'h1);
    cyc_wait(8);
    check(alarm_contact_out, 1'b1);
    clear(1);
    check(alarm_contact_out, 1'b0);
    host.wr(`ADDR_CONFIG, 32'h3);
    $display("test sensor and polarity done");
    drive(2, 0, 1'b1);
    cyc_wait(8);
    host.rd(`ADDR_STATUS, d);
    check(d, 32'h4);
    host.wr(`ADDR_MASK, 32'h0);
    cyc_wait(4);
    check(irq_out, 1'b0);
    host.wr(`ADDR_MASK, 32'hff);
    cyc_wait(4);
    check(irq_out, 1'b1);
    drive(2, 0, 1'b0);
    cyc_wait(4);
    host.wr(`ADDR_STATUS, 32'h4);
    host.rd(`ADDR_STATUS, d);
    check(d, 32'h0);
    clear(0);
    $display("test status and mask done");
    load <= 10'd120;
    mains(260);
    check(fault_code_out, 8'h00);
    load <= 10'd121;
    mains(249);
    check(fault_code_out, 8'h00);
    mains(1);
    check(fault_code_out, `OVERCURRENT_CODE);
    load <= 10'd50;
    // Let the load settle first, a still-present fault would re-latch
    cyc_wait(6);
    clear(2);
    check(fault_code_out, 8'h00);
    $display("test overcurrent done");
    running <= 1'b1;
    cyc_wait(20);
    host.run_clear();
    host.rd(`ADDR_RUN_TOTAL, d);
    check(d, 32'h0);
    $display("test run time done");
    results();
  end
endmodule
